// [rtl/bus_conn_pkg.sv]
/*
  shared constants of the two-wire bus connect controller: register map,
  control field positions, reset values, timing counts and state codes.
  assumes a 200 MHz core clock and a 30 ns link sampling clock.
*/
package bus_conn_pkg;

  // ****************************************************
  // register map (byte addresses, one word each)
  // ****************************************************
  localparam logic [3:0] CTRL_OFS      = 4'h0;
  localparam logic [3:0] STATUS_OFS    = 4'h4;
  localparam logic [3:0] CONN_CNT_OFS  = 4'h8;
  localparam int         ACC_VAR_BIT   = 0;
  localparam int         CARD_SUP_BIT  = 1;
  localparam logic [1:0] CTRL_RESET    = 2'h0;
  localparam logic [7:0] CONN_CNT_RST  = 8'h00;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int CORE_PERIOD_PS = 5000;
  localparam int LINK_PERIOD_PS = 30000;
  localparam int IDLE_TIME_NS   = 1300;
  // least time: round up to whole link cycles
  localparam int IDLE_CYCLES    =
    (IDLE_TIME_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  // cycles a released side is ignored while its echo passes the sync
  localparam logic [1:0] ECHO_GUARD = 2'h3;

  // ****************************************************
  // connect sequence
  // ****************************************************
  typedef enum logic [1:0] {
    ST_LOCKOUT   = 2'b00,
    ST_SEARCH    = 2'b01,
    ST_CARD_CHK  = 2'b10,
    ST_CONNECTED = 2'b11
  } conn_state_e;

endpackage

// [rtl/watch_link_if.sv]
/*
  carrier between the connect controller and the backplane watcher.
  arm is a core-domain level; event_tgl flips in the link domain once
  per stop or idle seen. both cross by synchronisers at the receiver.
*/
`timescale 1ns/1ps
interface watch_link_if;
  logic arm;
  logic event_tgl;
  modport ctrl    (output arm, input event_tgl);
  modport watcher (input arm, output event_tgl);
endinterface

// [rtl/bp_end_watch.sv]
/*
  backplane end-of-transaction watcher on the link sampling clock.
  assumes the link clock runs free and the bus pins are asynchronous.
*/
`timescale 1ns/1ps
module bp_end_watch #(
  parameter int IDLE_CYC = bus_conn_pkg::IDLE_CYCLES
) (
  // clock and reset
  input  wire logic link_clk_i,
  input  wire logic rst_n_i,
  // backplane pins
  input  wire logic bp_data_i,
  input  wire logic bp_clock_i,
  // to controller
  watch_link_if.watcher wl
);
  import bus_conn_pkg::*;

  initial begin
    if (IDLE_CYC < 2 || IDLE_CYC > 65535) begin
      $error("bp_end_watch: IDLE_CYC out of range");
    end
  end

  logic [1:0]  arm_ff;
  logic [1:0]  dat_ff;
  logic [1:0]  clk_ff;
  logic        dat_prev_ff;
  logic [15:0] idle_cnt_ff;
  logic        tgl_ff;
  logic        stop_seen;
  logic        idle_hit;
  logic        idle_fire;

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // released level, so no false rising edge follows reset
      arm_ff <= 2'h0;
      dat_ff <= 2'h3;
      clk_ff <= 2'h3;
    end else begin
      arm_ff <= {arm_ff[0], wl.arm};
      dat_ff <= {dat_ff[0], bp_data_i};
      clk_ff <= {clk_ff[0], bp_clock_i};
    end
  end

  assign stop_seen = arm_ff[1] && clk_ff[1] && dat_ff[1] && !dat_prev_ff;
  // idle reached: one event on the sample completing the run
  assign idle_hit  = idle_cnt_ff == 16'(IDLE_CYC);
  assign idle_fire = arm_ff[1] && dat_ff[1] && clk_ff[1]
                     && idle_cnt_ff == 16'(IDLE_CYC - 1);

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dat_prev_ff <= 1'b1;
      idle_cnt_ff <= 16'h0000;
    end else begin
      dat_prev_ff <= dat_ff[1];
      if (!arm_ff[1] || !dat_ff[1] || !clk_ff[1]) begin
        idle_cnt_ff <= 16'h0000;
      end else if (!idle_hit) begin
        idle_cnt_ff <= idle_cnt_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_ff <= 1'b0;
    end else if (stop_seen || idle_fire) begin
      tgl_ff <= !tgl_ff;
    end
  end

  assign wl.event_tgl = tgl_ff;

endmodule

// [rtl/bus_conn_ctrl.sv]
/*
  connect controller of a live-insertion two-wire bus buffer: lockout,
  precharge, start-up search, card-side check, wired-AND joining of the
  data and clock pairs, accelerator and ready control, Avalon-MM slave.
  assumes supply comparators and the enable pin arrive asynchronously and
  that open-drain pins are resolved outside from the output enables.
*/
`timescale 1ns/1ps
// Function
// - enable low gives low-current state
// - enable low: no accel, precharge, connection
// - ready low unless enabled and started
// - accel control input gates all four
// - lockout until main supply good
// - card supply variant waits for card
// - precharge active during lockout
// - search backplane for stop or idle
// - then require card data and clock high
// - connect only when all conditions hold
// - low on either side pulls both
// - high only when both sides released
// - accelerators only after connection
// - re-enable waits for transactions end
module bus_conn_ctrl #(
  parameter int IDLE_CYC = bus_conn_pkg::IDLE_CYCLES
) (
  // clocks, reset, clock enable
  input  wire logic        core_clk_i,
  input  wire logic        link_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // supplies and control pins
  input  wire logic        enable_i,
  input  wire logic        main_supply_ok_i,
  input  wire logic        card_supply_ok_i,
  input  wire logic        accel_control_i,
  // backplane data and clock lines
  input  wire logic        bp_data_i,
  output logic             bp_data_o,
  output logic             bp_data_oe_o,
  input  wire logic        bp_clock_i,
  output logic             bp_clock_o,
  output logic             bp_clock_oe_o,
  // card data and clock lines
  input  wire logic        card_data_i,
  output logic             card_data_o,
  output logic             card_data_oe_o,
  input  wire logic        card_clock_i,
  output logic             card_clock_o,
  output logic             card_clock_oe_o,
  // analog controls and ready flag
  output logic             precharge_o,
  output logic             accel_en_o,
  output logic             low_power_o,
  output logic             ready_o,
  output logic             ready_oe_o,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  import bus_conn_pkg::*;

  initial begin
    if (IDLE_CYC < 2 || IDLE_CYC > 65535) begin
      $error("bus_conn_ctrl: IDLE_CYC out of range");
    end
  end

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  // index: 0 enable, 1 main ok, 2 card ok, 3 accel,
  //        4 bp data, 5 bp clock, 6 card data, 7 card clock
  logic [7:0] pin_s1_ff;
  logic [7:0] pin_s2_ff;
  logic [2:0] tgl_ff;

  watch_link_if wl ();

  bp_end_watch #(
    .IDLE_CYC (IDLE_CYC)
  ) u_watch (
    .link_clk_i (link_clk_i),
    .rst_n_i    (rst_n_i),
    .bp_data_i  (bp_data_i),
    .bp_clock_i (bp_clock_i),
    .wl         (wl.watcher)
  );

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_ff <= 8'h00;
      pin_s2_ff <= 8'h00;
      tgl_ff    <= 3'h0;
    end else if (ce_i) begin
      pin_s1_ff <= {card_clock_i, card_data_i, bp_clock_i, bp_data_i,
                    accel_control_i, card_supply_ok_i,
                    main_supply_ok_i, enable_i};
      pin_s2_ff <= pin_s1_ff;
      tgl_ff    <= {tgl_ff[1:0], wl.event_tgl};
    end
  end

  logic en_s;
  logic main_ok_s;
  logic card_ok_s;
  logic acc_s;
  logic end_evt;

  assign en_s      = pin_s2_ff[0];
  assign main_ok_s = pin_s2_ff[1];
  assign card_ok_s = pin_s2_ff[2];
  assign acc_s     = pin_s2_ff[3];
  assign end_evt   = tgl_ff[2] ^ tgl_ff[1];

  // ****************************************************
  // control register
  // ****************************************************
  logic [1:0] ctrl_ff;
  logic [7:0] conn_cnt_ff;
  logic       lockout;

  // card supply gate on that variant
  assign lockout = !main_ok_s
                || (ctrl_ff[CARD_SUP_BIT] && !card_ok_s);

  // ****************************************************
  // connect sequence
  // ****************************************************
  conn_state_e state_ff;
  conn_state_e nxt_state;
  logic        connected;

  assign connected = state_ff == ST_CONNECTED;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_LOCKOUT: begin
        if (!lockout && en_s) begin
          nxt_state = ST_SEARCH;
        end
      end
      ST_SEARCH: begin
        if (end_evt) begin
          nxt_state = ST_CARD_CHK;
        end
      end
      ST_CARD_CHK: begin
        if (pin_s2_ff[6] && pin_s2_ff[7]) begin
          nxt_state = ST_CONNECTED;
        end
      end
      ST_CONNECTED: begin
        nxt_state = ST_CONNECTED;
      end
    endcase
    if (lockout || !en_s) begin
      nxt_state = ST_LOCKOUT;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_LOCKOUT;
    end else if (ce_i) begin
      state_ff <= nxt_state;
    end
  end

  // watcher runs only while searching, so stale events are not taken
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wl.arm <= 1'b0;
    end else if (ce_i) begin
      wl.arm <= nxt_state == ST_SEARCH;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conn_cnt_ff <= CONN_CNT_RST;
    end else if (ce_i && nxt_state == ST_CONNECTED && !connected) begin
      conn_cnt_ff <= conn_cnt_ff + 8'h01;
    end
  end

  // ****************************************************
  // wired-and joining
  // ****************************************************
  // pair 0 data, pair 1 clock. a side we pull low reads low on its
  // own; the origin flags and echo guards stop that from latching.
  logic [1:0] drv_bp_ff;
  logic [1:0] drv_card_ff;
  logic [1:0] nxt_drv_bp;
  logic [1:0] nxt_drv_card;
  logic [1:0] guard_bp_ff [2];
  logic [1:0] guard_card_ff [2];
  logic [1:0] bp_low;
  logic [1:0] card_low;

  assign bp_low   = ~pin_s2_ff[5:4];
  assign card_low = ~pin_s2_ff[7:6];

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      nxt_drv_bp[i]   = 1'b0;
      nxt_drv_card[i] = 1'b0;
      if (connected && nxt_state == ST_CONNECTED) begin
        nxt_drv_bp[i] = card_low[i] && !drv_card_ff[i]
                        && guard_card_ff[i] == 2'h0;
        nxt_drv_card[i] = bp_low[i] && !drv_bp_ff[i]
                          && guard_bp_ff[i] == 2'h0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drv_bp_ff   <= 2'h0;
      drv_card_ff <= 2'h0;
    end else if (ce_i) begin
      drv_bp_ff   <= nxt_drv_bp;
      drv_card_ff <= nxt_drv_card;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 2; i++) begin
        guard_bp_ff[i]   <= 2'h0;
        guard_card_ff[i] <= 2'h0;
      end
    end else if (ce_i) begin
      for (int i = 0; i < 2; i++) begin
        if (drv_bp_ff[i] && !nxt_drv_bp[i]) begin
          guard_bp_ff[i] <= ECHO_GUARD;
        end else if (guard_bp_ff[i] != 2'h0) begin
          guard_bp_ff[i] <= guard_bp_ff[i] - 2'h1;
        end
        if (drv_card_ff[i] && !nxt_drv_card[i]) begin
          guard_card_ff[i] <= ECHO_GUARD;
        end else if (guard_card_ff[i] != 2'h0) begin
          guard_card_ff[i] <= guard_card_ff[i] - 2'h1;
        end
      end
    end
  end

  assign bp_data_o       = 1'b0;
  assign bp_clock_o      = 1'b0;
  assign card_data_o     = 1'b0;
  assign card_clock_o    = 1'b0;
  assign bp_data_oe_o    = drv_bp_ff[0];
  assign bp_clock_oe_o   = drv_bp_ff[1];
  assign card_data_oe_o  = drv_card_ff[0];
  assign card_clock_oe_o = drv_card_ff[1];

  // ****************************************************
  // analog controls and ready flag
  // ****************************************************
  logic precharge_ff;
  logic accel_ff;
  logic low_power_ff;
  logic ready_ff;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      precharge_ff <= 1'b1;
      accel_ff     <= 1'b0;
      low_power_ff <= 1'b0;
      ready_ff     <= 1'b0;
    end else if (ce_i) begin
      low_power_ff <= !en_s;
      precharge_ff <= en_s && nxt_state != ST_CONNECTED;
      accel_ff     <= nxt_state == ST_CONNECTED
                   && (!ctrl_ff[ACC_VAR_BIT] || acc_s);
      ready_ff     <= en_s && nxt_state == ST_CONNECTED;
    end
  end

  assign precharge_o = precharge_ff;
  assign accel_en_o  = accel_ff;
  assign low_power_o = low_power_ff;
  // open drain: pulled low except when ready
  assign ready_o     = 1'b0;
  assign ready_oe_o  = !ready_ff;

  // ****************************************************
  // avalon-mm slave
  // ****************************************************
  // one wait cycle on every access; the answer is registered
  logic        ack_ff;
  logic [31:0] rdata_ff;
  logic        req;

  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_ff;
  assign avs_readdata    = rdata_ff;

  function automatic logic [31:0] reg_read(input logic [3:0] ofs);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (ofs)
      CTRL_OFS:     v[1:0] = ctrl_ff;
      STATUS_OFS:   v[7:0] = {drv_card_ff, drv_bp_ff, ready_ff,
                              lockout, state_ff};
      CONN_CNT_OFS: v[7:0] = conn_cnt_ff;
      default:      v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_ff <= req && !ack_ff;
      if (avs_read && !ack_ff) begin
        rdata_ff <= reg_read(avs_address);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= CTRL_RESET;
    end else if (ce_i && avs_write && ack_ff
                 && avs_address == CTRL_OFS) begin
      ctrl_ff <= avs_writedata[1:0];
    end
  end

endmodule

// [dv/bus_conn_properties.sv]
/*
  port assertions of the bus connect controller.
  assumes ce_i held high and the lines resolved from the output enables.
*/
`timescale 1ns/1ps
module bus_conn_properties (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // pins seen
  input wire logic enable_i,
  input wire logic main_supply_ok_i,
  input wire logic card_data_i,
  input wire logic bp_clock_i,
  // outputs watched
  input wire logic bp_data_oe_o,
  input wire logic bp_clock_oe_o,
  input wire logic card_data_oe_o,
  input wire logic card_clock_oe_o,
  input wire logic precharge_o,
  input wire logic accel_en_o,
  input wire logic low_power_o,
  input wire logic ready_oe_o
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // sync plus register is three edges, seen on the fourth sample
  AST_LOW_POWER: assert property (
    !enable_i [*4] |-> low_power_o) else $error("no low power");
  AST_DISABLED: assert property (
    low_power_o [*2] |-> !accel_en_o && !precharge_o && ready_oe_o)
    else $error("active while disabled");
  AST_ISOLATED: assert property (
    low_power_o |=> !(bp_data_oe_o || bp_clock_oe_o || card_data_oe_o
    || card_clock_oe_o)) else $error("joined while disabled");
  AST_READY_CONN: assert property (
    !ready_oe_o |-> !precharge_o && !low_power_o)
    else $error("ready without start-up");
  AST_ACCEL_CONN: assert property (
    accel_en_o |-> !ready_oe_o) else $error("accel before connect");
  AST_LOCKOUT: assert property (
    (!main_supply_ok_i && enable_i) [*4] |-> precharge_o && ready_oe_o)
    else $error("lockout not kept");
  // echo guard and sync need up to four edges
  AST_DATA_JOIN: assert property (
    (!ready_oe_o && !card_data_oe_o && !card_data_i) [*7]
    |-> bp_data_oe_o) else $error("data low not passed");
  AST_CLOCK_JOIN: assert property (
    (!ready_oe_o && !bp_clock_oe_o && !bp_clock_i) [*7]
    |-> card_clock_oe_o) else $error("clock low not passed");
  AST_DATA_RELEASE: assert property (
    card_data_i [*5] |-> !bp_data_oe_o) else $error("data held low");
  AST_CLOCK_RELEASE: assert property (
    bp_clock_i [*5] |-> !card_clock_oe_o) else $error("clock held low");
  COV_CONNECT: cover property ($fell(ready_oe_o));
  COV_JOIN: cover property ($rose(bp_data_oe_o));
  COV_DISABLE: cover property ($rose(low_power_o));
endmodule

// [dv/bus_peer_model.sv]
/*
  devices on both sides of the buffer with pull-ups on every line.
  assumes the bench commands each device pull; a free line floats high.
*/
`timescale 1ns/1ps
module bus_peer_model (
  // buffer enables {card clk, card data, bp clk, bp data}
  input  wire logic [3:0] dut_oe_i,
  // device pulls, same order
  input  wire logic [3:0] peer_pull_i,
  // resolved lines
  output logic      [3:0] line_o
);
  // ****************
  // wired-and
  // ****************
  assign line_o = ~(dut_oe_i | peer_pull_i);
endmodule

// [dv/tb_bus_conn_ctrl.sv]
/*
  bench of the bus connect controller: registers, start-up, joining,
  disable and supply variants. assumes the peer model resolves the lines.
*/
`timescale 1ns/1ps
module tb_bus_conn_ctrl;
  import bus_conn_pkg::*;
  // short idle keeps stop and idle paths apart in time
  localparam int IDLE = 12;
  logic        core_clk_i = 1'b0;
  logic        link_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        enable_i = 1'b1;
  logic        main_ok = 1'b0;
  logic        card_ok = 1'b0;
  logic        accel = 1'b0;
  logic [3:0]  pull = 4'h1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        pre;
  logic        acc_en;
  logic        low_pw;
  logic        rdy_oe;
  logic [31:0] q;
  wire  [3:0]  oe;
  wire  [3:0]  line;
  int          errors = 0;
  int          n_checks = 0;
  int          cyc = 0;

  always #2.5 core_clk_i = ~core_clk_i;
  initial begin
    #1.3;
    forever #15 link_clk_i = ~link_clk_i;
  end

  bus_conn_ctrl #(.IDLE_CYC(IDLE)) dut (
    .core_clk_i, .link_clk_i, .rst_n_i, .ce_i(1'b1), .enable_i,
    .main_supply_ok_i(main_ok), .card_supply_ok_i(card_ok),
    .accel_control_i(accel),
    .bp_data_i(line[0]), .bp_data_o(), .bp_data_oe_o(oe[0]),
    .bp_clock_i(line[1]), .bp_clock_o(), .bp_clock_oe_o(oe[1]),
    .card_data_i(line[2]), .card_data_o(), .card_data_oe_o(oe[2]),
    .card_clock_i(line[3]), .card_clock_o(), .card_clock_oe_o(oe[3]),
    .precharge_o(pre), .accel_en_o(acc_en), .low_power_o(low_pw),
    .ready_o(), .ready_oe_o(rdy_oe), .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);

  bus_peer_model peer (.dut_oe_i(oe), .peer_pull_i(pull), .line_o(line));

  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value at %0t: %h not %h", $time, s, e);
    end
  endtask

  // outputs are looked at on the falling edge, where they have settled
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic bus(input logic [3:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge core_clk_i);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    // waitrequest and read data are seen before the edge updates them
    do @(posedge core_clk_i);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wait_rdy(input int lim);
    int n;
    n = 0;
    while (rdy_oe !== 1'b0 && n++ < lim) @(negedge core_clk_i);
    chk(rdy_oe, 1'b0);
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_regs;
    chk(pre, 1'b1);
    chk(rdy_oe, 1'b1);
    bus(CTRL_OFS, 1'b0, 32'h0);
    chk(q, {30'h0, CTRL_RESET});
    bus(STATUS_OFS, 1'b0, 32'h0);
    chk(q[2:0], 3'h4);
    bus(4'hC, 1'b1, 32'hF);
    bus(4'hC, 1'b0, 32'h0);
    chk(q, 32'h0);
    bus(CTRL_OFS, 1'b1, 32'h3);
    bus(CTRL_OFS, 1'b0, 32'h0);
    chk(q, 32'h3);
    bus(CTRL_OFS, 1'b1, 32'h0);
  endtask

  task automatic t_start;
    @(posedge core_clk_i);
    pull <= 4'h0;
    wt(40);
    chk(rdy_oe, 1'b1);
    @(posedge core_clk_i);
    pull <= 4'h1;
    main_ok <= 1'b1;
    wt(60);
    chk(rdy_oe, 1'b1);
    // data rising with clock high, well before the idle count ends
    @(posedge core_clk_i);
    pull <= 4'h0;
    wait_rdy(40);
    chk(acc_en, 1'b1);
    chk(pre, 1'b0);
    bus(STATUS_OFS, 1'b0, 32'h0);
    chk(q[1:0], 2'h3);
  endtask

  task automatic t_join;
    @(posedge core_clk_i);
    pull <= 4'h4;
    wt(8);
    chk(line, 4'hA);
    @(posedge core_clk_i);
    pull <= 4'h0;
    wt(8);
    chk(line, 4'hF);
    @(posedge core_clk_i);
    pull <= 4'h2;
    wt(8);
    chk(line, 4'h5);
    @(posedge core_clk_i);
    pull <= 4'h0;
    wt(8);
    chk({oe, line}, 8'h0F);
  endtask

  task automatic t_disable;
    @(posedge core_clk_i);
    enable_i <= 1'b0;
    wt(8);
    chk(low_pw, 1'b1);
    chk({acc_en, pre, rdy_oe}, 3'h1);
    @(posedge core_clk_i);
    pull <= 4'h1;
    wt(8);
    chk(oe, 4'h0);
    @(posedge core_clk_i);
    pull <= 4'h8;
    enable_i <= 1'b1;
    wt(120);
    chk({low_pw, rdy_oe}, 2'h1);
    bus(STATUS_OFS, 1'b0, 32'h0);
    chk(q[1:0], 2'h2);
    @(posedge core_clk_i);
    pull <= 4'h0;
    wait_rdy(40);
    bus(CONN_CNT_OFS, 1'b0, 32'h0);
    chk(q, 32'h2);
  endtask

  task automatic t_variant;
    bus(CTRL_OFS, 1'b1, 32'h1);
    wt(4);
    chk(acc_en, 1'b0);
    @(posedge core_clk_i);
    accel <= 1'b1;
    wt(8);
    chk(acc_en, 1'b1);
    @(posedge core_clk_i);
    main_ok <= 1'b0;
    wt(8);
    chk({pre, rdy_oe, oe}, 6'h30);
    // card supply variant armed while the card supply is still down
    bus(CTRL_OFS, 1'b1, 32'h3);
    @(posedge core_clk_i);
    main_ok <= 1'b1;
    wt(120);
    chk(rdy_oe, 1'b1);
    @(posedge core_clk_i);
    card_ok <= 1'b1;
    wait_rdy(150);
    @(posedge core_clk_i);
    accel <= 1'b0;
    wt(8);
    chk(acc_en, 1'b0);
  endtask

  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      final_report;
    end
  end

  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    // pins need two sync edges and one register edge to settle
    wt(4);
    t_regs;
    t_start;
    t_join;
    t_disable;
    t_variant;
    final_report;
  end
endmodule

bind bus_conn_ctrl bus_conn_properties chk (
  .core_clk_i       (core_clk_i),
  .rst_n_i          (rst_n_i),
  .enable_i         (enable_i),
  .main_supply_ok_i (main_supply_ok_i),
  .card_data_i      (card_data_i),
  .bp_clock_i       (bp_clock_i),
  .bp_data_oe_o     (bp_data_oe_o),
  .bp_clock_oe_o    (bp_clock_oe_o),
  .card_data_oe_o   (card_data_oe_o),
  .card_clock_oe_o  (card_clock_oe_o),
  .precharge_o      (precharge_o),
  .accel_en_o       (accel_en_o),
  .low_power_o      (low_power_o),
  .ready_oe_o       (ready_oe_o)
);
